// ===== src/fec_pkg.sv
// shared constants and carriers for the flash command interpreter
package fec_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_SET_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_ERASE_ALL_A      = 8'h60;
  localparam logic [7:0] OP_ERASE_ALL_B      = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP       = 8'hB9;
  localparam logic [7:0] OP_WAKE_AND_ID      = 8'hAB;
  localparam logic [7:0] OP_MAKER_DEV_ID_X1  = 8'h90;
  localparam logic [7:0] OP_MAKER_DEV_ID_X2  = 8'h92;
  localparam logic [7:0] OP_MAKER_DEV_ID_X4  = 8'h94;
  localparam logic [7:0] OP_STANDARD_ID      = 8'h9F;
  localparam logic [7:0] OP_SOFT_RESET       = 8'h99;

  // ==========================================================================
  // frame geometry
  localparam logic [4:0] OPCODE_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS    = 5'h18;
  localparam logic [4:0] DUMMY_BITS   = 5'h18;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [1:0] STD_ID_BYTES = 2'h3;

  // ==========================================================================
  // timing, 200 MHz core clock
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned SLEEP_ENTRY_NS   = 3000;
  localparam int unsigned WAKE_NS          = 3000;
  localparam int unsigned WAKE_WITH_ID_NS  = 3000;
  localparam int unsigned ERASE_ALL_MS     = 20;
  // longest delays: round down, never below one cycle
  localparam int unsigned SLEEP_ENTRY_CYC  =
    (SLEEP_ENTRY_NS * 1000 / CLK_PERIOD_PS) > 0 ? SLEEP_ENTRY_NS * 1000 / CLK_PERIOD_PS : 1;
  localparam int unsigned WAKE_CYC         =
    (WAKE_NS * 1000 / CLK_PERIOD_PS) > 0 ? WAKE_NS * 1000 / CLK_PERIOD_PS : 1;
  localparam int unsigned WAKE_WITH_ID_CYC =
    (WAKE_WITH_ID_NS * 1000 / CLK_PERIOD_PS) > 0 ? WAKE_WITH_ID_NS * 1000 / CLK_PERIOD_PS : 1;
  localparam int unsigned ERASE_ALL_CYC    = ERASE_ALL_MS * 1000 * (1000000 / CLK_PERIOD_PS);

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       csN;
    logic       sclk;
    logic [3:0] io;
  } fec_pins_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } fec_pad_t;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_CMD    = 3'h1,
    PH_ADDR   = 3'h3,
    PH_DUMMY  = 3'h2,
    PH_OUT    = 3'h6,
    PH_POST   = 3'h7,
    PH_IGNORE = 3'h5
  } fec_phase_t;

  typedef enum logic [1:0] {
    BUSY_NONE  = 2'h0,
    BUSY_ERASE = 2'h1,
    BUSY_SLEEP = 2'h3,
    BUSY_WAKE  = 2'h2
  } fec_busy_t;

endpackage

// ===== src/fec_sync.sv
// two-stage synchroniser with edge detection on the settled copy
`timescale 1ns/1ps
`default_nettype none
module fec_sync #(
  parameter int WIDTH = 6
) (
  // clock and control
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             ce,
  // asynchronous inputs
  input  wire logic [WIDTH-1:0] asyncIn,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } fec_sync_state_t;

  fec_sync_state_t state_reg;
  fec_sync_state_t state_next;

  // ==========================================================================
  // next state
  always_comb begin
    state_next      = state_reg;
    state_next.meta = asyncIn;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  // idle levels: every input, select included, resets high
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= '{meta: {WIDTH{1'b1}}, sync: {WIDTH{1'b1}}, prev: {WIDTH{1'b1}}};
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // edges only from the second and third stage, never the first
  assign level = state_reg.sync;
  assign rise  = state_reg.sync & ~state_reg.prev;
  assign fall  = ~state_reg.sync & state_reg.prev;

endmodule
`default_nettype wire

// ===== src/fec_flash_cmd.sv
// command interpreter for erase-all, deep sleep, wake and identification
//
// Summary of operation
// - Erase-all uses opcode 60h or C7h and needs the write enable latch set.
// - Erase-all runs only if select rises right after the eighth opcode bit.
// - Select rise starts timed erase; busy flag high until done, latch cleared.
// - Erase-all only with protect bits 000/comp 0 or 111/comp 1.
// - Deep sleep opcode B9h plus select rise enters sleep after entry delay.
// - Deep sleep discarded unless select rises right after the eighth bit.
// - In deep sleep only wake-and-id and software reset are accepted.
// - Deep sleep command rejected while an internal cycle runs.
// - Select high with no cycle running means standby, not deep sleep.
// - Power loss ends deep sleep; device starts in standby.
// - Wake opcode ABh alone: commands resume after the wake delay.
// - ABh plus three dummy bytes streams the device id, MSB first, repeating.
// - Wake-and-id ignored while the busy flag is set.
// - 90h plus address gives maker then device id; address 1 swaps order.
// - 92h gives the same id readout over two data lines.
// - 94h gives the same id readout over four data lines.
// - 9Fh streams maker code, memory type, capacity on falling edges.
// - 9Fh not decoded while an erase or program cycle runs.
// - Select rise ends identification output at any point; standby follows once no wake delay or erase is running.
// - Opcode, address and dummy bits are sampled on serial clock rise.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_cmd
  import fec_pkg::*;
#(
  parameter int unsigned ERASE_ALL_CYCLES = ERASE_ALL_CYC,
  parameter logic [7:0]  MAKER_ID         = 8'h5A,  // arbitrary value
  parameter logic [7:0]  MEMORY_TYPE      = 8'h3C,  // arbitrary value
  parameter logic [7:0]  CAPACITY_CODE    = 8'h18,  // arbitrary value
  parameter logic [7:0]  DEVICE_ID        = 8'h17   // arbitrary value
) (
  // clock and control
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  // serial pins from the host
  input  wire fec_pins_t  pinIn,
  // protection configuration
  input  wire logic [2:0] blockProtectBits,
  input  wire logic       protectComplementBit,
  // serial pin drivers
  output fec_pad_t        pad,
  // status
  output logic            writeInProgressFlag,
  output logic            writeEnableLatchFlag,
  output logic            deepSleep,
  output logic            standby
);

  typedef struct packed {
    fec_phase_t  phase;
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [4:0]  cnt;
    logic [7:0]  shift;
    logic [3:0]  bitsLeft;
    logic [1:0]  byteIdx;
    fec_busy_t   busy;
    logic [31:0] timer;
    logic        write_in_progress_flag;
    logic        write_enable_latch_flag;
    logic        sleep;
    logic        standby;
    fec_pad_t    pad;
  } fec_state_t;

  fec_state_t state_reg;
  fec_state_t state_next;

  logic [5:0] syncLevel;
  logic [5:0] syncRise;
  logic [5:0] syncFall;

  fec_sync #(
    .WIDTH (6)
  ) u_sync (
    .mclk    (mclk),
    .srst    (srst),
    .ce      (ce),
    .asyncIn (pinIn),
    .level   (syncLevel),
    .rise    (syncRise),
    .fall    (syncFall)
  );

  logic       csHigh;
  logic       csRise;
  logic       csFall;
  logic       sclkRise;
  logic       sclkFall;
  logic [3:0] ioIn;
  logic       protectOk;
  logic       accepting;

  assign csHigh    = syncLevel[5];
  assign csRise    = syncRise[5];
  assign csFall    = syncFall[5];
  assign sclkRise  = syncRise[4];
  assign sclkFall  = syncFall[4];
  assign ioIn      = syncLevel[3:0];
  assign protectOk = (blockProtectBits == 3'h0 && !protectComplementBit) ||
                     (blockProtectBits == 3'h7 && protectComplementBit);
  // frames during the sleep entry or wake delay are not taken
  assign accepting = state_reg.busy != BUSY_SLEEP && state_reg.busy != BUSY_WAKE;

  // ==========================================================================
  // helpers
  function automatic logic [2:0] laneWidth(input logic [7:0] op);
    case (op)
      OP_MAKER_DEV_ID_X2: laneWidth = 3'h2;
      OP_MAKER_DEV_ID_X4: laneWidth = 3'h4;
      default:            laneWidth = 3'h1;
    endcase
  endfunction

  function automatic logic [7:0] idByte(input logic [7:0] op, input logic [1:0] idx, input logic swap);
    case (op)
      OP_WAKE_AND_ID: idByte = DEVICE_ID;
      OP_STANDARD_ID: begin
        case (idx)
          2'h0:    idByte = MAKER_ID;
          2'h1:    idByte = MEMORY_TYPE;
          default: idByte = CAPACITY_CODE;
        endcase
      end
      default: idByte = (idx[0] ^ swap) ? DEVICE_ID : MAKER_ID;
    endcase
  endfunction

  function automatic logic [1:0] nextIdx(input logic [7:0] op, input logic [1:0] idx);
    if (op == OP_STANDARD_ID) begin
      nextIdx = (idx == STD_ID_BYTES - 2'h1) ? 2'h0 : idx + 2'h1;
    end else begin
      nextIdx = {1'b0, ~idx[0]};
    end
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic [7:0] opc;
    logic [2:0] w;
    logic [7:0] src;
    logic [4:0] cntW;
    opc        = {state_reg.cmd[6:0], ioIn[0]};
    w          = laneWidth(state_reg.cmd);
    src        = state_reg.shift;
    cntW       = state_reg.cnt + {2'h0, w};
    state_next = state_reg;

    // self-timed internal cycles
    if (state_reg.busy != BUSY_NONE) begin
      if (state_reg.timer <= 32'h0000_0001) begin
        case (state_reg.busy)
          BUSY_ERASE: state_next.write_in_progress_flag   = 1'b0;
          BUSY_SLEEP: state_next.sleep = 1'b1;
          default:    state_next.sleep = state_reg.sleep;
        endcase
        state_next.busy  = BUSY_NONE;
        state_next.timer = 32'h0000_0000;
      end else begin
        state_next.timer = state_reg.timer - 32'h0000_0001;
      end
    end

    if (csRise) begin
      // deselect ends any frame, output included
      state_next.phase  = PH_IDLE;
      state_next.pad.oe = 4'h0;
      state_next.pad.out = 4'h0;
      if (state_reg.phase == PH_POST) begin
        case (state_reg.cmd)
          OP_ERASE_ALL_A, OP_ERASE_ALL_B: begin
            if (state_reg.write_enable_latch_flag && !state_reg.write_in_progress_flag && protectOk) begin
              state_next.write_in_progress_flag   = 1'b1;
              state_next.write_enable_latch_flag   = 1'b0;
              state_next.busy  = BUSY_ERASE;
              state_next.timer = ERASE_ALL_CYCLES;
            end
          end
          OP_DEEP_SLEEP: begin
            if (!state_reg.write_in_progress_flag) begin
              state_next.busy  = BUSY_SLEEP;
              state_next.timer = 32'(SLEEP_ENTRY_CYC);
            end
          end
          OP_SET_WRITE_ENABLE: begin
            if (!state_reg.write_in_progress_flag) begin
              state_next.write_enable_latch_flag = 1'b1;
            end
          end
          OP_WAKE_AND_ID: begin
            if (state_reg.sleep) begin
              state_next.sleep = 1'b0;
              state_next.busy  = BUSY_WAKE;
              state_next.timer = 32'(WAKE_CYC);
            end
          end
          OP_SOFT_RESET: begin
            if (!state_reg.write_in_progress_flag) begin
              state_next.sleep = 1'b0;
              state_next.write_enable_latch_flag   = 1'b0;
            end
          end
          default: state_next.phase = PH_IDLE;
        endcase
      end else if (state_reg.phase == PH_OUT && state_reg.cmd == OP_WAKE_AND_ID && state_reg.sleep) begin
        state_next.sleep = 1'b0;
        state_next.busy  = BUSY_WAKE;
        state_next.timer = 32'(WAKE_WITH_ID_CYC);
      end
    end else if (csFall) begin
      state_next.phase = accepting ? PH_CMD : PH_IGNORE;
      state_next.cmd   = 8'h00;
      state_next.cnt   = 5'h00;
    end else if (!csHigh && sclkRise) begin
      case (state_reg.phase)
        PH_CMD: begin
          state_next.cmd = opc;
          state_next.cnt = state_reg.cnt + 5'h01;
          if (state_reg.cnt == OPCODE_BITS - 5'h01) begin
            state_next.cnt = 5'h00;
            if (state_reg.sleep && opc != OP_WAKE_AND_ID && opc != OP_SOFT_RESET) begin
              state_next.phase = PH_IGNORE;
            end else begin
              case (opc)
                OP_ERASE_ALL_A, OP_ERASE_ALL_B, OP_DEEP_SLEEP,
                OP_SET_WRITE_ENABLE, OP_SOFT_RESET: begin
                  state_next.phase = PH_POST;
                end
                OP_WAKE_AND_ID: begin
                  state_next.phase = state_reg.write_in_progress_flag ? PH_IGNORE : PH_POST;
                end
                OP_MAKER_DEV_ID_X1, OP_MAKER_DEV_ID_X2, OP_MAKER_DEV_ID_X4: begin
                  state_next.phase = PH_ADDR;
                end
                OP_STANDARD_ID: begin
                  state_next.phase    = state_reg.write_in_progress_flag ? PH_IGNORE : PH_OUT;
                  state_next.shift    = idByte(opc, 2'h0, 1'b0);
                  state_next.byteIdx  = 2'h1;
                  state_next.bitsLeft = BYTE_BITS;
                end
                default: state_next.phase = PH_IGNORE;
              endcase
            end
          end
        end
        PH_ADDR: begin
          case (w)
            3'h2:    state_next.addr = {state_reg.addr[21:0], ioIn[1:0]};
            3'h4:    state_next.addr = {state_reg.addr[19:0], ioIn};
            default: state_next.addr = {state_reg.addr[22:0], ioIn[0]};
          endcase
          state_next.cnt = cntW;
          if (cntW == ADDR_BITS) begin
            state_next.phase    = PH_OUT;
            state_next.shift    = idByte(state_reg.cmd, 2'h0, state_next.addr[0]);
            state_next.byteIdx  = 2'h1;
            state_next.bitsLeft = BYTE_BITS;
          end
        end
        PH_POST: begin
          // more clocks after the opcode: only the id form of wake allows them
          if (state_reg.cmd == OP_WAKE_AND_ID) begin
            state_next.phase = PH_DUMMY;
            state_next.cnt   = 5'h01;
          end else begin
            state_next.phase = PH_IGNORE;
          end
        end
        PH_DUMMY: begin
          state_next.cnt = state_reg.cnt + 5'h01;
          if (state_reg.cnt == DUMMY_BITS - 5'h01) begin
            state_next.phase    = PH_OUT;
            state_next.shift    = DEVICE_ID;
            state_next.byteIdx  = 2'h0;
            state_next.bitsLeft = BYTE_BITS;
          end
        end
        default: state_next.phase = state_reg.phase;
      endcase
    end else if (!csHigh && sclkFall && state_reg.phase == PH_OUT) begin
      // reload at a byte boundary, then drive the top bits of the byte
      if (state_reg.bitsLeft == 4'h0) begin
        src                = idByte(state_reg.cmd, state_reg.byteIdx, state_reg.addr[0]);
        state_next.byteIdx = nextIdx(state_reg.cmd, state_reg.byteIdx);
      end
      case (w)
        3'h2: begin
          state_next.pad.out = {2'h0, src[7:6]};
          state_next.pad.oe  = 4'h3;
          state_next.shift   = {src[5:0], 2'h0};
        end
        3'h4: begin
          state_next.pad.out = src[7:4];
          state_next.pad.oe  = 4'hF;
          state_next.shift   = {src[3:0], 4'h0};
        end
        default: begin
          state_next.pad.out = {2'h0, src[7], 1'b0};
          state_next.pad.oe  = 4'h2;
          state_next.shift   = {src[6:0], 1'b0};
        end
      endcase
      state_next.bitsLeft = ((state_reg.bitsLeft == 4'h0) ? BYTE_BITS : state_reg.bitsLeft) - {1'b0, w};
    end

    // standby is distinct from deep sleep
    state_next.standby = csHigh && state_next.busy == BUSY_NONE && !state_next.write_in_progress_flag &&
                         !state_next.sleep;
  end

  // ==========================================================================
  // state register; reset stands for power-up, so sleep is never kept
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg       <= '0;
      state_reg.phase <= PH_IDLE;
      state_reg.busy  <= BUSY_NONE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign pad                  = state_reg.pad;
  assign writeInProgressFlag  = state_reg.write_in_progress_flag;
  assign writeEnableLatchFlag = state_reg.write_enable_latch_flag;
  assign deepSleep            = state_reg.sleep;
  assign standby              = state_reg.standby;

endmodule
`default_nettype wire

// ===== sim/fec_flash_cmd_asserts.sv
// assertion checker for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
module fec_flash_cmd_asserts
  import fec_pkg::*;
#(
  parameter int unsigned ERASE_ALL_CYCLES = 100
) (
  // clock and control
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       ce,
  // pins
  input wire fec_pins_t  pinIn,
  input wire fec_pad_t   pad,
  // protection and status
  input wire logic [2:0] blockProtectBits,
  input wire logic       protectComplementBit,
  input wire logic       writeInProgressFlag,
  input wire logic       writeEnableLatchFlag,
  input wire logic       deepSleep,
  input wire logic       standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // busy length counter; tolerance covers the synchroniser lag
  logic [31:0] busyCnt_reg;
  logic [31:0] busyCnt_next;
  always_comb busyCnt_next = writeInProgressFlag ? busyCnt_reg + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge mclk) busyCnt_reg <= srst ? 32'h0000_0000 : busyCnt_next;
  // ==========================================================================
  // properties
  property p_erase_needs_latch;
    $rose(writeInProgressFlag) |-> $past(writeEnableLatchFlag);
  endproperty
  a_erase_needs_latch: assert property (p_erase_needs_latch) else $error("erase without latch");
  property p_erase_clears_latch;
    $rose(writeInProgressFlag) |-> !writeEnableLatchFlag;
  endproperty
  a_erase_clears_latch: assert property (p_erase_clears_latch) else $error("latch kept at erase");
  property p_erase_protect;
    $rose(writeInProgressFlag) |->
      (blockProtectBits == 3'h0 && !protectComplementBit) || (blockProtectBits == 3'h7 && protectComplementBit);
  endproperty
  a_erase_protect: assert property (p_erase_protect) else $error("erase while protected");
  property p_erase_after_cs;
    $rose(writeInProgressFlag) |-> pinIn.csN && $past(pinIn.csN, 2);
  endproperty
  a_erase_after_cs: assert property (p_erase_after_cs) else $error("erase before select rise");
  property p_erase_length;
    $fell(writeInProgressFlag) |-> busyCnt_reg + 2 >= ERASE_ALL_CYCLES && busyCnt_reg <= ERASE_ALL_CYCLES + 2;
  endproperty
  a_erase_length: assert property (p_erase_length) else $error("erase length wrong");
  property p_sleep_idle;
    $rose(deepSleep) |-> !writeInProgressFlag && pinIn.csN;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered while busy");
  property p_sleep_locks_latch;
    $rose(writeEnableLatchFlag) |-> !$past(deepSleep);
  endproperty
  a_sleep_locks_latch: assert property (p_sleep_locks_latch) else $error("latch set in sleep");
  property p_standby_excl;
    (writeInProgressFlag && $past(writeInProgressFlag)) || (deepSleep && $past(deepSleep)) |-> !standby;
  endproperty
  a_standby_excl: assert property (p_standby_excl) else $error("standby while busy or asleep");
  property p_oe_released;
    pinIn.csN [*6] |-> pad.oe == 4'h0;
  endproperty
  a_oe_released: assert property (p_oe_released) else $error("output driven while deselected");
  property p_oe_lanes;
    pad.oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_lanes: assert property (p_oe_lanes) else $error("illegal lane enable");
  c_erase: cover property ($rose(writeInProgressFlag));
  c_sleep: cover property ($rose(deepSleep));
  c_quad: cover property (pad.oe == 4'hF);
endmodule
bind fec_flash_cmd fec_flash_cmd_asserts #(.ERASE_ALL_CYCLES(ERASE_ALL_CYCLES)) fec_flash_cmd_asserts_i (
  .mclk(mclk), .srst(srst), .ce(ce), .pinIn(pinIn), .pad(pad), .blockProtectBits(blockProtectBits),
  .protectComplementBit(protectComplementBit), .writeInProgressFlag(writeInProgressFlag),
  .writeEnableLatchFlag(writeEnableLatchFlag), .deepSleep(deepSleep), .standby(standby));
`default_nettype wire

// ===== sim/fec_host_model.sv
// host serial controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module fec_host_model
  import fec_pkg::*;
(
  // pins toward the flash
  output wire fec_pins_t pinIn,
  input  wire fec_pad_t  pad
);
  localparam realtime HALF = 62.5;
  logic       csN;
  logic       sclk;
  logic       hostOe;
  logic [3:0] hostIo;
  logic [3:0] ioLine;
  // released host lines show the inverse, never a stale level
  assign ioLine = (pad.out & pad.oe) | (~pad.oe & (hostOe ? hostIo : ~hostIo));
  assign pinIn = {csN, sclk, ioLine};
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostOe = 1'b1;
    hostIo = 4'h0;
  end
  // ==========================================================================
  // one framed transfer: opcode, then aBits of address or dummy, then rBits read
  task automatic frame(input logic [7:0] op, input int w, input logic [23:0] ab, input int aBits,
                       input int rBits, output logic [31:0] rx);
    int i;
    int n;
    csN = 1'b0;
    #(HALF);
    for (i = 7; i >= 0; i--) begin
      hostIo = {3'h0, op[i]};
      #(HALF) sclk = 1'b1;
      #(HALF) sclk = 1'b0;
    end
    for (i = aBits - 1; i >= 0; i -= w) begin
      for (n = 0; n < w; n++) hostIo[w - 1 - n] = ab[i - n];
      #(HALF) sclk = 1'b1;
      #(HALF) sclk = 1'b0;
    end
    hostOe = 1'b0;
    rx = 32'h0000_0000;
    for (i = 0; i < rBits; i += w) begin
      #(HALF) sclk = 1'b1;
      if (w == 1) rx = {rx[30:0], ioLine[1]};
      else for (n = w - 1; n >= 0; n--) rx = {rx[30:0], ioLine[n]};
      #(HALF) sclk = 1'b0;
    end
    // select stays low until here, clock parks low
    #(HALF) csN = 1'b1;
    hostOe = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== sim/fec_flash_cmd_bench.sv
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`default_nettype none
module fec_flash_cmd_bench
  import fec_pkg::*;
();
  localparam logic [7:0] MK = 8'hA1; // arbitrary value
  localparam logic [7:0] MT = 8'h42; // arbitrary value
  localparam logic [7:0] CP = 8'h3E; // arbitrary value
  localparam logic [7:0] DV = 8'hC5; // arbitrary value
  localparam int unsigned ERASE_CYC = 2000;
  logic        mclk;
  logic        srst;
  logic        ce;
  logic [2:0]  bp;
  logic        cmp;
  wire         fec_pins_t pinIn;
  wire         fec_pad_t pad;
  wire         write_in_progress_flag;
  wire         write_enable_latch_flag;
  wire         ds;
  wire         sb;
  logic [31:0] rx;
  int          fail_count;
  int          num_checks;
  fec_flash_cmd #(.ERASE_ALL_CYCLES(ERASE_CYC), .MAKER_ID(MK), .MEMORY_TYPE(MT), .CAPACITY_CODE(CP),
                  .DEVICE_ID(DV)) fec_flash_cmd_i (
    .mclk(mclk), .srst(srst), .ce(ce), .pinIn(pinIn), .blockProtectBits(bp), .protectComplementBit(cmp),
    .pad(pad), .writeInProgressFlag(write_in_progress_flag), .writeEnableLatchFlag(write_enable_latch_flag), .deepSleep(ds), .standby(sb));
  fec_host_model fec_host_model_i (.pinIn(pinIn), .pad(pad));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================================
  // helpers
  task automatic chk1(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op);
    fec_host_model_i.frame(op, 1, 24'h00_0000, 0, 0, rx);
  endtask
  task automatic rd(input logic [7:0] op, input int w, input logic [23:0] ab, input int aBits,
                    input int rBits, input logic [31:0] exp);
    fec_host_model_i.frame(op, w, ab, aBits, rBits, rx);
    chk32("id data", exp, rx);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000 && write_in_progress_flag !== 1'b0; i++) @(negedge mclk);
    chk1("busy end", 1'b0, write_in_progress_flag);
  endtask
  task automatic set_prot(input logic [2:0] b, input logic c);
    @(negedge mclk);
    bp = b;
    cmp = c;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    chk1("busy", 1'b0, write_in_progress_flag);
    chk1("sleep", 1'b0, ds);
    chk1("standby", 1'b1, sb);
  endtask
  task automatic t_ids;
    rd(OP_STANDARD_ID, 1, 24'h00_0000, 0, 32, {MK, MT, CP, MK});
    rd(OP_STANDARD_ID, 1, 24'h00_0000, 0, 12, {20'h0_0000, MK, MT[7:4]});
    rd(OP_STANDARD_ID, 1, 24'h00_0000, 0, 8, {24'h00_0000, MK});
    rd(OP_MAKER_DEV_ID_X1, 1, 24'h00_0000, 24, 24, {8'h00, MK, DV, MK});
    rd(OP_MAKER_DEV_ID_X1, 1, 24'h00_0001, 24, 16, {16'h0000, DV, MK});
    rd(OP_MAKER_DEV_ID_X2, 2, 24'h00_0000, 24, 16, {16'h0000, MK, DV});
    rd(OP_MAKER_DEV_ID_X2, 2, 24'h00_0001, 24, 16, {16'h0000, DV, MK});
    rd(OP_MAKER_DEV_ID_X4, 4, 24'h00_0000, 24, 16, {16'h0000, MK, DV});
    rd(OP_MAKER_DEV_ID_X4, 4, 24'h00_0001, 24, 16, {16'h0000, DV, MK});
    rd(OP_WAKE_AND_ID, 1, 24'h00_0000, 24, 24, {8'h00, DV, DV, DV});
  endtask
  task automatic t_erase;
    cmd(OP_ERASE_ALL_A);
    waitc(10);
    chk1("busy", 1'b0, write_in_progress_flag);
    cmd(OP_SET_WRITE_ENABLE);
    chk1("latch", 1'b1, write_enable_latch_flag);
    for (int i = 0; i < 2; i++) begin
      set_prot(i == 0 ? 3'h1 : 3'h0, i == 1);
      cmd(OP_ERASE_ALL_A);
      waitc(10);
      chk1("busy", 1'b0, write_in_progress_flag);
    end
    set_prot(3'h0, 1'b0);
    fec_host_model_i.frame(OP_ERASE_ALL_B, 1, 24'h00_0000, 1, 0, rx);
    waitc(10);
    chk1("busy", 1'b0, write_in_progress_flag);
    cmd(OP_ERASE_ALL_A);
    waitc(10);
    chk1("busy", 1'b1, write_in_progress_flag);
    chk1("latch", 1'b0, write_enable_latch_flag);
    chk1("standby", 1'b0, sb);
    cmd(OP_DEEP_SLEEP);
    waitc(650);
    chk1("sleep", 1'b0, ds);
    cmd(OP_WAKE_AND_ID);
    cmd(OP_STANDARD_ID);
    chk1("busy", 1'b1, write_in_progress_flag);
    wait_idle();
    chk1("standby", 1'b1, sb);
    set_prot(3'h7, 1'b1);
    cmd(OP_SET_WRITE_ENABLE);
    cmd(OP_ERASE_ALL_B);
    waitc(10);
    chk1("busy", 1'b1, write_in_progress_flag);
    wait_idle();
    set_prot(3'h0, 1'b0);
  endtask
  task automatic t_sleep;
    fec_host_model_i.frame(OP_DEEP_SLEEP, 1, 24'h00_0000, 1, 0, rx);
    waitc(700);
    chk1("sleep", 1'b0, ds);
    cmd(OP_DEEP_SLEEP);
    // frozen cycles must not count toward the entry delay
    ce = 1'b0;
    waitc(100);
    ce = 1'b1;
    waitc(500);
    chk1("sleep", 1'b0, ds);
    waitc(100);
    chk1("sleep", 1'b1, ds);
    chk1("standby", 1'b0, sb);
    cmd(OP_SET_WRITE_ENABLE);
    chk1("latch", 1'b0, write_enable_latch_flag);
    cmd(OP_WAKE_AND_ID);
    chk1("sleep", 1'b0, ds);
    cmd(OP_SET_WRITE_ENABLE);
    chk1("latch", 1'b0, write_enable_latch_flag);
    waitc(650);
    cmd(OP_SET_WRITE_ENABLE);
    chk1("latch", 1'b1, write_enable_latch_flag);
    cmd(OP_DEEP_SLEEP);
    waitc(650);
    cmd(OP_SOFT_RESET);
    chk1("sleep", 1'b0, ds);
    cmd(OP_DEEP_SLEEP);
    waitc(650);
    rd(OP_WAKE_AND_ID, 1, 24'h00_0000, 24, 8, {24'h00_0000, DV});
    chk1("sleep", 1'b0, ds);
    waitc(650);
    cmd(OP_SET_WRITE_ENABLE);
    chk1("latch", 1'b1, write_enable_latch_flag);
  endtask
  // ==========================================================================
  // run control
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    $display("unexpected watchdog: expected done seen hang");
    end_sim();
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    bp = 3'h0;
    cmp = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    waitc(4);
    t_reset();
    t_ids();
    t_erase();
    t_sleep();
    end_sim();
  end
endmodule
`default_nettype wire
